// [tcc_consts.vh]
// Constants for the timer core control block: register offsets, fields, resets.
// Assumes an Avalon-MM slave with 32-bit data, one register per aligned word.
//
// How it works
// - Force strobe register always reads zero
// - Force bit performs programmed compare action now
// - Forced compare never sets channel flag
// - Force beats simultaneous match; flag stays clear
// - Unimplemented channel bits ignore writes, read zero
// - Sixteen-bit up counter ticks on prescaled clock
// - Counter writes only in special mode
// - First period after load may differ
// - Word counter access moves all sixteen bits in one access
// - Run enable low halts whole timer
// - Divide-by-64 tap stops when timer inactive
// - Halt in wait stops timer and accumulator
// - Halt in freeze stops counter, accumulator runs
// - Fast clear: capture read/compare write clears flag
// - Fast clear: counter access clears wrap flag
// - Precision select chooses eight-bit or legacy divider
// - Precision select takes first write only
// - Two-bit action: none, toggle, low, high
// - Overflow toggle beats forced compare
// - Legacy divider is power of two 1..128
`ifndef TCC_CONSTS_VH
`define TCC_CONSTS_VH

// ==========================================================
// Register indices (byte address is four times the index)
`define TCC_IDX_IOSEL 6'h00
`define TCC_IDX_FORCE 6'h01
`define TCC_IDX_CNT_HI 6'h04
`define TCC_IDX_CNT_LO 6'h05
`define TCC_IDX_CTRL1 6'h06
`define TCC_IDX_OVF_TGL 6'h07
`define TCC_IDX_ACT_HI 6'h08
`define TCC_IDX_ACT_LO 6'h09
`define TCC_IDX_CTRL2 6'h0D
`define TCC_IDX_CHFLAG 6'h0E
`define TCC_IDX_WRAPFLAG 6'h0F
`define TCC_IDX_CMP_BASE 6'h10
`define TCC_IDX_PREC 6'h2E
`define TCC_IDX_CNT_WORD 6'h30
`define TCC_IDX_MODE 6'h31

// ==========================================================
// Field positions
`define TCC_NCH 6
`define TCC_CTRL1_RUN 7
`define TCC_CTRL1_WAIT 6
`define TCC_CTRL1_FRZ 5
`define TCC_CTRL1_FFC 4
`define TCC_CTRL1_PREC 3
`define TCC_CTRL2_OVIE 7
`define TCC_WRAP_BIT 7
`define TCC_MODE_SPECIAL 0

// ==========================================================
// Reset values and widths
`define TCC_RST_8 8'h00
`define TCC_RST_16 16'h0000
`define TCC_RST_32 32'h0000_0000
`define TCC_RST_CH 6'h00
`define TCC_CNT_MAX 16'hFFFF
`define TCC_CNT_ONE 16'h0001
`define TCC_DIV64_MASK 6'h3F

`endif

// [tcc_timer_core.v]
// Timer core control: free-running counter, force-compare strobe, control one.
// Assumes Avalon-MM master on core_clk; wait, freeze, special-mode pins from other clock logic.
`timescale 1ns/1ps
`include "tcc_consts.vh"

module tcc_timer_core
(
  input wire core_clk,
  input wire nrst,
  input wire [5:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  input wire cpu_wait_mode,
  input wire debug_freeze,
  input wire special_mode,
  output reg [5:0] compare_out,
  output reg [5:0] channel_event_flag,
  output reg counter_wrap_flag,
  output reg div64_tick,
  output reg accum_enable
);

  // ==========================================================
  // Pin synchronisers: two flops, first read only by second
  reg [2:0] sync1_reg;
  reg [2:0] sync2_reg;
  always @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      sync1_reg <= 3'h0;
      sync2_reg <= 3'h0;
    end
    else
    begin
      sync1_reg <= {special_mode, debug_freeze, cpu_wait_mode};
      sync2_reg <= sync1_reg;
    end
  end
  wire wait_s = sync2_reg[0];
  wire frz_s = sync2_reg[1];
  wire spec_s = sync2_reg[2];

  // ==========================================================
  // Registers
  reg [7:0] ctrl1_reg;
  reg prec_locked_reg;
  reg [5:0] iosel_reg;
  reg [5:0] ovf_tgl_reg;
  reg [11:0] act_reg;
  reg [7:0] ctrl2_reg;
  reg [7:0] prec_reg;
  reg [15:0] cnt_reg;
  reg [7:0] presc_reg;
  reg [6:0] legacy_reg;
  reg [15:0] cmp_reg [0:5];
  reg resp_reg;

  // Bus decode; one wait state so every access answers in two cycles
  wire req = (avs_read | avs_write) & ~resp_reg;
  wire wr = avs_write & req;
  wire rd = avs_read & req;
  wire [7:0] wd = avs_writedata[7:0];
  wire cmp_hit = (avs_address[5:4] == 2'b01) & (avs_address[3:1] < 3'd6);
  wire [2:0] cmp_ch = avs_address[3:1];

  // ==========================================================
  // Run conditions
  wire run_en = ctrl1_reg[`TCC_CTRL1_RUN];
  wire wait_halt = ctrl1_reg[`TCC_CTRL1_WAIT] & wait_s;
  wire timer_active = run_en & ~wait_halt;
  wire cnt_run = timer_active & ~(ctrl1_reg[`TCC_CTRL1_FRZ] & frz_s);

  // Divider selection: legacy power of two or precision 8-bit
  wire use_prec = ctrl1_reg[`TCC_CTRL1_PREC];
  wire [7:0] legacy_div = (8'h01 << ctrl2_reg[2:0]) - 8'h01;
  wire [7:0] div_max = use_prec ? prec_reg : legacy_div;
  wire tick = timer_active & (presc_reg == div_max);

  // Counter load and wrap
  wire cnt_wr_hi = wr & spec_s & (avs_address == `TCC_IDX_CNT_HI);
  wire cnt_wr_lo = wr & spec_s & (avs_address == `TCC_IDX_CNT_LO);
  wire cnt_wr_w = wr & spec_s & (avs_address == `TCC_IDX_CNT_WORD);
  wire cnt_load = cnt_wr_hi | cnt_wr_lo | cnt_wr_w;
  wire cnt_step = tick & cnt_run;
  wire wrap = cnt_step & (cnt_reg == `TCC_CNT_MAX) & ~cnt_load;
  wire cnt_access = req & ((avs_address == `TCC_IDX_CNT_HI) | (avs_address == `TCC_IDX_CNT_LO)
                    | (avs_address == `TCC_IDX_CNT_WORD));
  wire ffc = ctrl1_reg[`TCC_CTRL1_FFC];

  // ==========================================================
  // Prescaler and counter; a load leaves the prescaler running, so the
  // first period after it may be short
  always @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      presc_reg <= `TCC_RST_8;
      legacy_reg <= 7'h00;
      cnt_reg <= `TCC_RST_16;
      div64_tick <= 1'b0;
      accum_enable <= 1'b0;
    end
    else
    begin
      if (timer_active)
        presc_reg <= tick ? `TCC_RST_8 : presc_reg + 8'h01;
      legacy_reg <= timer_active ? legacy_reg + 7'h01 : legacy_reg;
      div64_tick <= timer_active & (legacy_reg[5:0] == `TCC_DIV64_MASK);
      accum_enable <= timer_active;
      if (cnt_wr_w)
        cnt_reg <= avs_writedata[15:0];
      else if (cnt_wr_hi)
        cnt_reg <= {wd, cnt_reg[7:0]};
      else if (cnt_wr_lo)
        cnt_reg <= {cnt_reg[15:8], wd};
      else if (cnt_step)
        cnt_reg <= cnt_reg + `TCC_CNT_ONE;
    end
  end

  // ==========================================================
  // Compare match and forced compare
  reg [5:0] match;
  reg [5:0] force_v;
  reg [5:0] out_next;
  reg [5:0] flag_next;
  integer i;
  always @*
  begin
    match = 6'h00;
    force_v = 6'h00;
    out_next = compare_out;
    flag_next = channel_event_flag;
    for (i = 0; i < `TCC_NCH; i = i + 1)
    begin
      match[i] = iosel_reg[i] & cnt_step & (cmp_reg[i] == cnt_reg);
      force_v[i] = wr & (avs_address == `TCC_IDX_FORCE) & wd[i] & iosel_reg[i];
      if (wrap & ovf_tgl_reg[i] & iosel_reg[i])
        out_next[i] = ~compare_out[i];
      else if (force_v[i] | match[i])
        case (act_reg[2*i +: 2])
          2'b01: out_next[i] = ~compare_out[i];
          2'b10: out_next[i] = 1'b0;
          2'b11: out_next[i] = 1'b1;
          default: out_next[i] = compare_out[i];
        endcase
      // Software and fast clears first, so a new event still wins
      if (wr & (avs_address == `TCC_IDX_CHFLAG) & wd[i])
        flag_next[i] = 1'b0;
      if (ffc & cmp_hit & (cmp_ch == i) & ((rd & ~iosel_reg[i]) | (wr & iosel_reg[i])))
        flag_next[i] = 1'b0;
      if (match[i] & ~force_v[i])
        flag_next[i] = 1'b1;
    end
  end

  // ==========================================================
  // Register writes and flags
  always @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ctrl1_reg <= `TCC_RST_8;
      prec_locked_reg <= 1'b0;
      iosel_reg <= `TCC_RST_CH;
      ovf_tgl_reg <= `TCC_RST_CH;
      act_reg <= 12'h000;
      ctrl2_reg <= `TCC_RST_8;
      prec_reg <= `TCC_RST_8;
      compare_out <= `TCC_RST_CH;
      channel_event_flag <= `TCC_RST_CH;
      counter_wrap_flag <= 1'b0;
      // Spelled out so the loop index stays owned by the compare logic
      cmp_reg[0] <= `TCC_RST_16;
      cmp_reg[1] <= `TCC_RST_16;
      cmp_reg[2] <= `TCC_RST_16;
      cmp_reg[3] <= `TCC_RST_16;
      cmp_reg[4] <= `TCC_RST_16;
      cmp_reg[5] <= `TCC_RST_16;
    end
    else
    begin
      compare_out <= out_next;
      channel_event_flag <= flag_next;
      // Wrap set wins over any clear in the same cycle
      if (wrap)
        counter_wrap_flag <= 1'b1;
      else if ((ffc & cnt_access) | (wr & (avs_address == `TCC_IDX_WRAPFLAG) & wd[`TCC_WRAP_BIT]))
        counter_wrap_flag <= 1'b0;
      if (wr)
      begin
        case (avs_address)
          `TCC_IDX_CTRL1:
          begin
            ctrl1_reg[7:4] <= wd[7:4];
            if (!prec_locked_reg)
            begin
              ctrl1_reg[`TCC_CTRL1_PREC] <= wd[`TCC_CTRL1_PREC];
              prec_locked_reg <= 1'b1;
            end
          end
          `TCC_IDX_IOSEL: iosel_reg <= wd[5:0];
          `TCC_IDX_OVF_TGL: ovf_tgl_reg <= wd[5:0];
          `TCC_IDX_ACT_HI: act_reg[11:8] <= wd[3:0];
          `TCC_IDX_ACT_LO: act_reg[7:0] <= wd;
          `TCC_IDX_CTRL2: ctrl2_reg <= {wd[7], 4'h0, wd[2:0]};
          `TCC_IDX_PREC: prec_reg <= wd;
          default:
          begin
            if (cmp_hit)
            begin
              if (avs_address[0])
                cmp_reg[cmp_ch] <= {cmp_reg[cmp_ch][15:8], wd};
              else
                cmp_reg[cmp_ch] <= {wd, cmp_reg[cmp_ch][7:0]};
            end
          end
        endcase
      end
    end
  end

  // ==========================================================
  // Read mux; force strobe and unmapped addresses read zero
  reg [31:0] rdata;
  always @*
  begin
    rdata = `TCC_RST_32;
    case (avs_address)
      `TCC_IDX_FORCE: rdata = `TCC_RST_32;
      `TCC_IDX_IOSEL: rdata = {26'h0, iosel_reg};
      `TCC_IDX_CNT_HI: rdata = {24'h0, cnt_reg[15:8]};
      `TCC_IDX_CNT_LO: rdata = {24'h0, cnt_reg[7:0]};
      `TCC_IDX_CNT_WORD: rdata = {16'h0, cnt_reg};
      `TCC_IDX_CTRL1: rdata = {24'h0, ctrl1_reg[7:3], 3'h0};
      `TCC_IDX_OVF_TGL: rdata = {26'h0, ovf_tgl_reg};
      `TCC_IDX_ACT_HI: rdata = {28'h0, act_reg[11:8]};
      `TCC_IDX_ACT_LO: rdata = {24'h0, act_reg[7:0]};
      `TCC_IDX_CTRL2: rdata = {24'h0, ctrl2_reg};
      `TCC_IDX_CHFLAG: rdata = {26'h0, channel_event_flag};
      `TCC_IDX_WRAPFLAG: rdata = {24'h0, counter_wrap_flag, 7'h0};
      `TCC_IDX_PREC: rdata = {24'h0, prec_reg};
      `TCC_IDX_MODE: rdata = {31'h0, spec_s};
      default:
        if (cmp_hit)
          rdata = {24'h0, avs_address[0] ? cmp_reg[cmp_ch][7:0] : cmp_reg[cmp_ch][15:8]};
    endcase
  end

  // Answer: waitrequest high in request cycle, low the next
  always @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      resp_reg <= 1'b0;
      avs_waitrequest <= 1'b1;
      avs_readdata <= `TCC_RST_32;
    end
    else
    begin
      resp_reg <= req;
      avs_waitrequest <= ~req;
      if (rd)
        avs_readdata <= rdata;
    end
  end

endmodule // tcc_timer_core

// [tcc_timer_core_sva.sv]
// Checker for the timer core control block: bus timing, force strobe, flags, tick.
// Assumes the bind below attaches it to tcc_timer_core on core_clk.
`timescale 1ns/1ps
`include "tcc_consts.vh"

module tcc_timer_core_sva
(
  input wire core_clk,
  input wire nrst,
  input wire [5:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [31:0] avs_readdata,
  input wire avs_waitrequest,
  input wire [5:0] channel_event_flag,
  input wire counter_wrap_flag,
  input wire div64_tick,
  input wire accum_enable
);
  // ==========================================================
  // Properties, all in the core clock domain
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  wire req = avs_read | avs_write;
  wire take = req & avs_waitrequest;
  property p_ans; $rose(req) |=> !avs_waitrequest; endproperty
  property p_one; !avs_waitrequest |=> avs_waitrequest; endproperty
  property p_fz; take && avs_read && avs_address == `TCC_IDX_FORCE |=> avs_readdata == 32'h0000_0000; endproperty
  property p_cl; take && avs_read && avs_address == `TCC_IDX_CTRL1 |=> avs_readdata[2:0] == 3'h0; endproperty
  // Only flags that rise in the same cycle as the forced bits are illegal
  property p_nf;
    take && avs_write && avs_address == `TCC_IDX_FORCE
    |=> (channel_event_flag & ~$past(channel_event_flag) & $past(avs_writedata[5:0])) == 6'h00;
  endproperty
  property p_d0; !accum_enable && !$past(accum_enable) |-> !div64_tick; endproperty
  property p_dp; div64_tick |=> !div64_tick [*8]; endproperty
  property p_wh; $rose(counter_wrap_flag) && !req |=> counter_wrap_flag; endproperty
  a_ans: assert property (p_ans) else $error("no answer one cycle after request");
  a_one: assert property (p_one) else $error("answer longer than one cycle");
  a_fz: assert property (p_fz) else $error("force strobe read not zero");
  a_cl: assert property (p_cl) else $error("control low bits not zero");
  a_nf: assert property (p_nf) else $error("forced channel flag set");
  a_d0: assert property (p_d0) else $error("tick while timer inactive");
  a_dp: assert property (p_dp) else $error("tick spacing too short");
  a_wh: assert property (p_wh) else $error("wrap flag did not hold");
  c_force: cover property (take && avs_write && avs_address == `TCC_IDX_FORCE);
  c_wrap: cover property ($rose(counter_wrap_flag));
  c_tick: cover property (div64_tick);
endmodule // tcc_timer_core_sva

bind tcc_timer_core tcc_timer_core_sva u_sva (.core_clk(core_clk), .nrst(nrst), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .channel_event_flag(channel_event_flag),
  .counter_wrap_flag(counter_wrap_flag), .div64_tick(div64_tick), .accum_enable(accum_enable));

// [tcc_timer_core_tb_top.sv]
// Testbench for the timer core control block, driven over Avalon-MM.
// Assumes a one-cycle answer after each taken request; read results queued.
`timescale 1ns/1ps
`include "tcc_consts.vh"

module tcc_timer_core_tb_top;
  reg core_clk, nrst, avs_read, avs_write, cpu_wait_mode, debug_freeze, special_mode;
  reg [5:0] avs_address;
  reg [31:0] avs_writedata;
  wire [31:0] avs_readdata;
  wire avs_waitrequest, counter_wrap_flag, div64_tick, accum_enable;
  wire [5:0] compare_out, channel_event_flag;
  int fail_count = 0;
  int total_checks = 0;
  logic [31:0] exp_q[$];
  logic [15:0] v;

  tcc_timer_core u_dut (.core_clk(core_clk), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .cpu_wait_mode(cpu_wait_mode), .debug_freeze(debug_freeze),
    .special_mode(special_mode), .compare_out(compare_out), .channel_event_flag(channel_event_flag),
    .counter_wrap_flag(counter_wrap_flag), .div64_tick(div64_tick), .accum_enable(accum_enable));

  // ==========================================================
  // Clock, checking and closing
  always #12.5 core_clk = ~core_clk;
  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    total_checks++;
    if (seen !== want)
    begin
      fail_count++;
      $display("unexpected t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask
  task automatic close_out;
    $display("checks=%0d mismatches=%0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Read results appear at the edge that samples waitrequest low
  always @(posedge core_clk)
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0)
      chk(avs_readdata, exp_q.pop_front());

  // ==========================================================
  // Bus tasks: request held until waitrequest is seen low
  task automatic acc(input logic [5:0] a, input logic [31:0] d, input logic r);
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= r;
    avs_write <= !r;
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic rd(input logic [5:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    acc(a, 32'h0000_0000, 1'b1);
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  // Program both action bytes, force, then look at pins and flags
  task automatic act(input logic [7:0] hi, input logic [7:0] lo, input logic [7:0] f, input logic [5:0] w);
    acc(`TCC_IDX_ACT_HI, {24'h00_0000, hi}, 1'b0);
    acc(`TCC_IDX_ACT_LO, {24'h00_0000, lo}, 1'b0);
    acc(`TCC_IDX_FORCE, {24'h00_0000, f}, 1'b0);
    chk(32'(compare_out), 32'(w));
    chk(32'(channel_event_flag), 32'h0000_0000);
  endtask

  // ==========================================================
  // Main sequence
  initial
  begin
    {core_clk, nrst, avs_read, avs_write, cpu_wait_mode, debug_freeze, special_mode} = 7'h00;
    avs_address = 6'h00;
    avs_writedata = 32'h0000_0000;
    void'($urandom(32'h9253));
    wt(8);
    nrst <= 1'b1;
    acc(`TCC_IDX_IOSEL, 32'h0000_00FF, 1'b0);
    rd(`TCC_IDX_IOSEL, 32'h0000_003F);
    act(8'h05, 8'h55, 8'hFF, 6'h3F);
    act(8'h0A, 8'hAA, 8'h3F, 6'h00);
    act(8'h0F, 8'hFF, 8'h15, 6'h15);
    act(8'h00, 8'h00, 8'h3F, 6'h15);
    rd(`TCC_IDX_FORCE, 32'h0000_0000);
    acc(`TCC_IDX_CTRL1, 32'h0000_00FF, 1'b0);
    rd(`TCC_IDX_CTRL1, 32'h0000_00F8);
    acc(`TCC_IDX_CTRL1, 32'h0000_0000, 1'b0);
    rd(`TCC_IDX_CTRL1, 32'h0000_0008);
    // Loads only in special mode; counter halted meanwhile
    special_mode <= 1'b1;
    wt(4);
    v = 16'($urandom);
    acc(`TCC_IDX_CNT_WORD, {16'h0000, v}, 1'b0);
    rd(`TCC_IDX_CNT_WORD, {16'h0000, v});
    rd(`TCC_IDX_CNT_HI, {24'h00_0000, v[15:8]});
    rd(`TCC_IDX_CNT_LO, {24'h00_0000, v[7:0]});
    special_mode <= 1'b0;
    wt(4);
    acc(`TCC_IDX_CNT_WORD, {16'h0000, ~v}, 1'b0);
    rd(`TCC_IDX_CNT_WORD, {16'h0000, v});
    special_mode <= 1'b1;
    debug_freeze <= 1'b1;
    wt(4);
    acc(`TCC_IDX_CNT_WORD, 32'h0000_FFF0, 1'b0);
    acc(`TCC_IDX_CTRL1, 32'h0000_00A0, 1'b0);
    wt(20);
    rd(`TCC_IDX_CNT_WORD, 32'h0000_FFF0);
    chk(32'(accum_enable), 32'h0000_0001);
    // Overflow toggle on ch0 meets a forced drive high; the toggle must win
    acc(`TCC_IDX_OVF_TGL, 32'h0000_0001, 1'b0);
    acc(`TCC_IDX_ACT_LO, 32'h0000_0003, 1'b0);
    acc(`TCC_IDX_CMP_BASE, 32'h0000_0080, 1'b0);
    debug_freeze <= 1'b0;
    acc(`TCC_IDX_CTRL1, 32'h0000_0090, 1'b0);
    wt(13); // FFF0 wraps at the taking edge of the next write
    acc(`TCC_IDX_FORCE, 32'h0000_0001, 1'b0);
    chk(32'(compare_out), 32'h0000_0014);
    wt(24);
    chk(32'(counter_wrap_flag), 32'h0000_0001);
    acc(`TCC_IDX_CNT_LO, 32'h0000_0000, 1'b0);
    wt(2);
    chk(32'(counter_wrap_flag), 32'h0000_0000);
    // Fast clear: compare write clears ch0, capture read clears ch1
    acc(`TCC_IDX_CMP_BASE | 6'h01, 32'h0000_0001, 1'b0);
    chk(32'(channel_event_flag), 32'h0000_003E);
    acc(`TCC_IDX_IOSEL, 32'h0000_003D, 1'b0);
    rd(`TCC_IDX_CMP_BASE | 6'h02, 32'h0000_0000);
    chk(32'(channel_event_flag), 32'h0000_003C);
    acc(`TCC_IDX_IOSEL, 32'h0000_003F, 1'b0);
    acc(`TCC_IDX_CTRL1, 32'h0000_00C0, 1'b0);
    cpu_wait_mode <= 1'b1;
    wt(4);
    chk(32'(accum_enable), 32'h0000_0000);
    cpu_wait_mode <= 1'b0;
    wt(70);
    chk(32'(accum_enable), 32'h0000_0001);
    acc(`TCC_IDX_CTRL1, 32'h0000_0000, 1'b0);
    wt(2);
    chk(32'(accum_enable), 32'h0000_0000);
    // Second reset reopens precision choice; legacy divide by eight, 40 edges
    nrst <= 1'b0;
    wt(2);
    nrst <= 1'b1;
    acc(`TCC_IDX_CTRL2, 32'h0000_0003, 1'b0);
    acc(`TCC_IDX_CTRL1, 32'h0000_0080, 1'b0);
    wt(37);
    acc(`TCC_IDX_CTRL1, 32'h0000_0008, 1'b0);
    rd(`TCC_IDX_CNT_WORD, 32'h0000_0005);
    rd(`TCC_IDX_CTRL1, 32'h0000_0000);
    close_out();
  end

  // Hang guard, far beyond the expected run
  initial
  begin
    wt(20000);
    fail_count++;
    close_out();
  end
endmodule // tcc_timer_core_tb_top
